// ==== inc/ovst_pkg.sv ====
// Purpose: shared constants, types and functions of the overvoltage stage timer
// Assumes: 40 MHz ref_clk, one processing tick every 5 ms
// Notes: levels and thresholds in 0.01 %Un, ratios in 0.01, times in ticks, the time dial in 0.01 s
package ovst_pkg;
  localparam int CLK_NS = 25;
  localparam int TICK_NS = 5_000_000;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  localparam int DIAL_NS = 10_000_000;
  localparam int DIAL_TICKS = DIAL_NS / TICK_NS;
  localparam int CNT_W = 19;
  localparam int MEAS_W = 16;
  localparam int RAT_W = 17;
  localparam int SET_W = 13;
  localparam int VT_W = 20;
  localparam int PRI_W = 32;
  localparam int PCT = 100;
  localparam int RESET_PCT = 97;
  localparam int PRI_DIV = 1000;
  localparam logic [RAT_W-1:0] RAT_ONE = 17'h00064;
  localparam logic [RAT_W-1:0] RAT_MAX = 17'h1E848;
  localparam logic [CNT_W-1:0] T_MAX = 19'h57E40;
  localparam logic [CNT_W-1:0] DEF_FIXED = 19'h00008;
  localparam logic [CNT_W-1:0] DEF_REL = 19'h0000C;
  localparam logic [SET_W-1:0] DEF_DIAL = 13'h0005;
  localparam logic [SET_W-1:0] DEF_EXP = 13'h0064;
  localparam logic [2:0] RST_MODE = 3'h0;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_COUNT   = 2'b01,
    ST_RELEASE = 2'b10,
    ST_TRIP    = 2'b11
  } ovst_state_t;

  typedef enum logic [2:0] {
    MD_ON       = 3'b000,
    MD_BLOCKED  = 3'b001,
    MD_TEST     = 3'b010,
    MD_TEST_BLK = 3'b011,
    MD_OFF      = 3'b100
  } ovst_mode_t;

  function automatic logic [RAT_W-1:0] ovst_ratio(input logic [MEAS_W-1:0] m, input logic [MEAS_W-1:0] thr);
    logic [31:0] q;
    q = (thr == '0) ? 32'hFFFFFFFF : (32'(m) * 32'(PCT)) / 32'(thr);
    return (q > 32'(RAT_MAX)) ? RAT_MAX : q[RAT_W-1:0];
  endfunction
endpackage

// ==== core/ovst_tick.sv ====
// Purpose: divides ref_clk into the 5 ms processing tick
// Assumes: CYCLES of at least two
// Notes: tick is a one-cycle pulse
`timescale 1ns/1ps
module ovst_tick import ovst_pkg::*; #(
  parameter int CYCLES = TICK_CYC
) (
  input  wire logic ref_clk,
  input  wire logic resetn,
  output logic      tick
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic         tick_reg;
  logic         tick_next;

  always_comb begin
    tick_next = (cnt_reg == W'(CYCLES - 1));
    cnt_next = tick_next ? '0 : cnt_reg + 1'b1;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule

// ==== core/ovst_inverse_time_mode.sv ====
// Purpose: inverse-time operating time in ticks
// Assumes: ratio and exponent in 0.01 units, dial in 0.01 s
// Notes: log2 and exp2 are piecewise linear, a few percent error
`timescale 1ns/1ps
module ovst_inverse_time_mode import ovst_pkg::*; (
  input  wire logic             ref_clk,
  input  wire logic             resetn,
  input  wire logic [RAT_W-1:0] ratio,
  input  wire logic [SET_W-1:0] dial,
  input  wire logic [SET_W-1:0] expo,
  output logic      [CNT_W-1:0] op_ticks
);
  logic [CNT_W-1:0] t_reg;
  logic [CNT_W-1:0] t_next;
  logic [15:0]      lr;
  logic [31:0]      e;
  logic [47:0]      den;
  logic [47:0]      q;

  function automatic logic [15:0] log2_q8(input logic [RAT_W-1:0] x);
    logic [4:0]       msb;
    logic [RAT_W-1:0] nrm;
    msb = '0;
    for (int i = 0; i < RAT_W; i++) begin
      if (x[i]) msb = 5'(i);
    end
    nrm = x << (5'(RAT_W - 1) - msb);
    return {3'h0, msb, nrm[RAT_W-2 -: 8]};
  endfunction

  // Same approximation on both sides keeps ratio > 1 strictly positive
  always_comb begin
    lr = log2_q8(ratio) - log2_q8(RAT_ONE);
    e = (32'(lr) * 32'(expo)) / 32'(PCT);
    den = (e[31:8] > 24'h000017) ? 48'hFFFFFFFFFFFF : ((48'h100 + 48'(e[7:0])) << e[12:8]) - 48'h100;
    q = (den == '0) ? 48'hFFFFFFFFFFFF : (48'(dial) * 48'(DIAL_TICKS) * 48'h100) / den;
    if (ratio <= RAT_ONE || q > 48'(T_MAX)) begin
      t_next = T_MAX;
    end else begin
      t_next = q[CNT_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      t_reg <= T_MAX;
    end else begin
      t_reg <= t_next;
    end
  end

  assign op_ticks = t_reg;
endmodule

// ==== core/ovst_stage.sv ====
// Purpose: start, trip and release timing of one overvoltage stage
// Assumes: settings and levels come from logic on ref_clk
// Notes: block_in is asynchronous and is synchronised
`timescale 1ns/1ps
module ovst_stage import ovst_pkg::*; #(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  input  wire logic                    block_in,
  input  wire logic [MEAS_W-1:0]       measured_level_a,
  input  wire logic [MEAS_W-1:0]       measured_level_b,
  input  wire logic [MEAS_W-1:0]       measured_level_c,
  input  wire logic [MEAS_W-1:0]       threshold,
  input  wire logic [1:0]              pickup_phases,
  input  wire logic                    inverse_time_mode,
  input  wire logic [CNT_W-1:0]        fixed_delay,
  input  wire logic [SET_W-1:0]        time_dial,
  input  wire logic [SET_W-1:0]        inverse_time_mode_exponent,
  input  wire logic [CNT_W-1:0]        release_delay,
  input  wire logic                    delayed_release_en,
  input  wire logic                    cnt_reset_after_release,
  input  wire logic                    cont_during_release,
  input  wire logic [2:0]              stage_operating_mode,
  input  wire logic [VT_W-1:0]         vt_primary_volts,
  output logic                         start,
  output logic                         trip,
  output logic                         blocked,
  output logic [CNT_W-1:0]             expected_time,
  output logic signed [CNT_W:0]        remaining_time,
  output logic [RAT_W-1:0]             ratio_a,
  output logic [RAT_W-1:0]             ratio_b,
  output logic [RAT_W-1:0]             ratio_c,
  output logic [RAT_W-1:0]             ratio_gov,
  output logic [PRI_W-1:0]             threshold_primary,
  output logic [2:0]                   stage_mode_status
);
  logic                tick;
  logic [CNT_W-1:0]    inverse_time_mode_ticks;
  logic [CNT_W-1:0]    target;
  logic [MEAS_W-1:0]   meas [3];
  logic [RAT_W-1:0]    rat [3];
  logic [RAT_W-1:0]    rat_gov;
  logic                mode_off;
  logic                blk_now;
  logic                pu_now;
  logic                pu_eff;
  logic                over;
  logic                under;
  logic [1:0]          pu_cnt;
  logic [1:0]          need;
  logic [CNT_W-1:0]    op_inc;
  logic [CNT_W-1:0]    rel_inc;
  logic                rel_done;
  logic [39:0]         pri_full;

  logic                blk_s1_reg, blk_s2_reg, blk_smp_reg;
  logic                blk_s1_next, blk_s2_next, blk_smp_next;
  logic [2:0]          pu_ph_reg, pu_ph_next;
  ovst_state_t         state_reg, state_next;
  logic [CNT_W-1:0]    op_cnt_reg, op_cnt_next;
  logic [CNT_W-1:0]    rel_cnt_reg, rel_cnt_next;
  logic                start_reg, start_next;
  logic                trip_reg, trip_next;
  logic                blocked_reg, blocked_next;
  logic [CNT_W-1:0]    exp_reg, exp_next;
  logic signed [CNT_W:0] rem_reg, rem_next;
  logic [RAT_W-1:0]    rat_reg [4];
  logic [RAT_W-1:0]    rat_next [4];
  logic [PRI_W-1:0]    pri_reg, pri_next;
  logic [2:0]          mode_reg, mode_next;

  ovst_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .ref_clk (ref_clk),
    .resetn  (resetn),
    .tick    (tick)
  );

  ovst_inverse_time_mode u_inverse_time_mode (
    .ref_clk  (ref_clk),
    .resetn   (resetn),
    .ratio    (rat_gov),
    .dial     (time_dial),
    .expo     (inverse_time_mode_exponent),
    .op_ticks (inverse_time_mode_ticks)
  );

  assign meas[0] = measured_level_a;
  assign meas[1] = measured_level_b;
  assign meas[2] = measured_level_c;

  // Blocking input capture
  always_comb begin
    blk_s1_next = block_in;
    blk_s2_next = blk_s1_reg;
    blk_smp_next = tick ? blk_s2_reg : blk_smp_reg;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      blk_s1_reg <= 1'b0;
      blk_s2_reg <= 1'b0;
      blk_smp_reg <= 1'b0;
    end else begin
      blk_s1_reg <= blk_s1_next;
      blk_s2_reg <= blk_s2_next;
      blk_smp_reg <= blk_smp_next;
    end
  end

  // Per-phase pick-up with hysteresis, evaluated on the tick
  always_comb begin
    pu_cnt = '0;
    over = 1'b0;
    under = 1'b0;
    pu_ph_next = pu_ph_reg;
    for (int i = 0; i < 3; i++) begin
      over = meas[i] > threshold;
      under = (32'(meas[i]) * 32'(PCT)) < (32'(threshold) * 32'(RESET_PCT));
      if (tick) pu_ph_next[i] = over | (pu_ph_reg[i] & ~under);
      pu_cnt = pu_cnt + 2'(pu_ph_next[i]);
    end
    need = (pickup_phases == 2'h0) ? 2'h1 : pickup_phases;
    pu_now = pu_cnt >= need;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pu_ph_reg <= '0;
    end else begin
      pu_ph_reg <= pu_ph_next;
    end
  end

  assign mode_off = (ovst_mode_t'(stage_operating_mode) == MD_OFF);
  // Sampled this tick, so a late block only counts from the next tick
  assign blk_now = (tick ? blk_s2_reg : blk_smp_reg) | stage_operating_mode[0];
  assign pu_eff = pu_now & ~blk_now;
  assign target = inverse_time_mode ? inverse_time_mode_ticks : fixed_delay;
  assign op_inc = (op_cnt_reg == T_MAX) ? op_cnt_reg : op_cnt_reg + 1'b1;
  assign rel_inc = rel_cnt_reg + 1'b1;
  assign rel_done = rel_inc >= release_delay;

  // Start, trip and release sequencing
  always_comb begin
    state_next = state_reg;
    op_cnt_next = op_cnt_reg;
    rel_cnt_next = rel_cnt_reg;
    start_next = start_reg;
    trip_next = trip_reg;
    blocked_next = blocked_reg;
    if (mode_off) begin
      state_next = ST_IDLE;
      op_cnt_next = '0;
      rel_cnt_next = '0;
      start_next = 1'b0;
      trip_next = 1'b0;
      blocked_next = 1'b0;
    end else if (tick) begin
      blocked_next = pu_now & blk_now;
      if (pu_eff && state_reg != ST_TRIP) begin
        start_next = 1'b1;
        rel_cnt_next = '0;
        op_cnt_next = op_inc;
        state_next = ST_COUNT;
        if (op_inc > target) begin
          trip_next = 1'b1;
          state_next = ST_TRIP;
        end
      end else if (!pu_eff) begin
        unique case (state_reg)
          ST_IDLE: begin
            start_next = 1'b0;
          end
          ST_COUNT: begin
            // Blocking and drop share one release path
            if (release_delay == '0) begin
              state_next = ST_IDLE;
              start_next = 1'b0;
              op_cnt_next = '0;
            end else begin
              state_next = ST_RELEASE;
              rel_cnt_next = '0;
              start_next = delayed_release_en;
              if (!cnt_reset_after_release) begin
                op_cnt_next = '0;
              end else if (cont_during_release) begin
                op_cnt_next = op_inc;
              end
            end
          end
          ST_RELEASE: begin
            rel_cnt_next = rel_inc;
            if (rel_done) begin
              state_next = ST_IDLE;
              start_next = 1'b0;
              op_cnt_next = '0;
            end else if (cont_during_release && cnt_reset_after_release) begin
              op_cnt_next = op_inc;
            end
          end
          ST_TRIP: begin
            // A trip ends with the pick-up, no release hold
            state_next = ST_IDLE;
            start_next = 1'b0;
            trip_next = 1'b0;
            op_cnt_next = '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      op_cnt_reg <= '0;
      rel_cnt_reg <= '0;
      start_reg <= 1'b0;
      trip_reg <= 1'b0;
      blocked_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_cnt_reg <= op_cnt_next;
      rel_cnt_reg <= rel_cnt_next;
      start_reg <= start_next;
      trip_reg <= trip_next;
      blocked_reg <= blocked_next;
    end
  end

  // Read-only status values
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      rat[i] = ovst_ratio(meas[i], threshold);
      rat_next[i] = rat[i];
    end
    rat_gov = (rat[0] > rat[1]) ? rat[0] : rat[1];
    rat_gov = (rat_gov > rat[2]) ? rat_gov : rat[2];
    rat_next[3] = rat_gov;
    exp_next = target;
    if (state_reg == ST_COUNT || state_reg == ST_RELEASE) begin
      rem_next = $signed({1'b0, target}) - $signed({1'b0, op_cnt_reg});
    end else begin
      rem_next = '0;
    end
    pri_full = (40'(threshold) * 40'(vt_primary_volts)) / 40'(PRI_DIV);
    pri_next = (pri_full[39:PRI_W] != '0) ? '1 : pri_full[PRI_W-1:0];
    mode_next = stage_operating_mode;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      exp_reg <= '0;
      rem_reg <= '0;
      for (int i = 0; i < 4; i++) rat_reg[i] <= '0;
      pri_reg <= '0;
      mode_reg <= RST_MODE;
    end else begin
      exp_reg <= exp_next;
      rem_reg <= rem_next;
      for (int i = 0; i < 4; i++) rat_reg[i] <= rat_next[i];
      pri_reg <= pri_next;
      mode_reg <= mode_next;
    end
  end

  assign start = start_reg;
  assign trip = trip_reg;
  assign blocked = blocked_reg;
  assign expected_time = exp_reg;
  assign remaining_time = rem_reg;
  assign ratio_a = rat_reg[0];
  assign ratio_b = rat_reg[1];
  assign ratio_c = rat_reg[2];
  assign ratio_gov = rat_reg[3];
  assign threshold_primary = pri_reg;
  assign stage_mode_status = mode_reg;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence s_pick;
    tick && pu_eff && !mode_off;
  endsequence
  sequence s_drop;
    tick && !pu_eff && !mode_off && state_reg == ST_COUNT && release_delay != '0;
  endsequence

  property p_blk_sample;
    !tick |=> $stable(blk_smp_reg);
  endproperty
  a_blk_sample: assert property (p_blk_sample)
    else $error("block sample changed off tick");

  property p_start;
    s_pick and (state_reg != ST_TRIP) |=> start && !blocked;
  endproperty
  a_start: assert property (p_start)
    else $error("start missing after pick-up");

  property p_blocked;
    tick && pu_now && blk_now && !mode_off |=> blocked && !trip;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("blocked not raised");

  property p_blk_release;
    tick && pu_now && blk_now && !mode_off && state_reg == ST_COUNT && !delayed_release_en |=> !start;
  endproperty
  a_blk_release: assert property (p_blk_release)
    else $error("start held after blocking");

  property p_instant;
    s_pick and (state_reg == ST_IDLE && target == '0) |=> start && trip;
  endproperty
  a_instant: assert property (p_instant)
    else $error("instant trip missing");

  property p_fixed;
    s_pick and (!inverse_time_mode && state_reg == ST_COUNT && op_inc > fixed_delay) |=> trip ##1 trip || !tick;
  endproperty
  a_fixed: assert property (p_fixed)
    else $error("fixed delay trip missing");

  property p_hold;
    s_drop and delayed_release_en |=> start && state_reg == ST_RELEASE;
  endproperty
  a_hold: assert property (p_hold)
    else $error("start not held in release");

  property p_no_hold;
    s_drop and !delayed_release_en |=> !start;
  endproperty
  a_no_hold: assert property (p_no_hold)
    else $error("start not cleared at drop");

  property p_cnt_clear;
    s_drop and !cnt_reset_after_release |=> op_cnt_reg == '0;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear)
    else $error("counter not cleared at drop");

  property p_continue;
    tick && !pu_eff && !mode_off && state_reg == ST_RELEASE && cont_during_release && cnt_reset_after_release
      && !rel_done && op_cnt_reg != T_MAX |=> op_cnt_reg == $past(op_cnt_reg) + 1'b1;
  endproperty
  a_continue: assert property (p_continue)
    else $error("counter stalled in release");
endmodule

// ==== verif/ovst_front.sv ====
// Purpose: blocking matrix and voltage front end facing the stage
// Assumes: bench commands change at the falling edge of ref_clk
// Notes: unselected phases sit at a fixed healthy level
`timescale 1ns/1ps
module ovst_front import ovst_pkg::*; #(
  parameter logic [MEAS_W-1:0] LOW_LVL = 16'h0FA0
) (
  input  wire logic [MEAS_W-1:0] lvl_cmd,
  input  wire logic [2:0]        phase_mask,
  input  wire logic              blk_cmd,
  output logic                   block_in,
  output logic [MEAS_W-1:0]      measured_level_a,
  output logic [MEAS_W-1:0]      measured_level_b,
  output logic [MEAS_W-1:0]      measured_level_c
);
  // Bench places blocking whole ticks ahead of any delay expiry
  assign block_in         = blk_cmd;
  assign measured_level_a = phase_mask[0] ? lvl_cmd : LOW_LVL;
  assign measured_level_b = phase_mask[1] ? lvl_cmd : LOW_LVL;
  assign measured_level_c = phase_mask[2] ? lvl_cmd : LOW_LVL;
endmodule

// ==== verif/test_ovst_stage.sv ====
// Purpose: self-checking bench for the overvoltage stage timer
// Assumes: short tick of TC clocks, inputs driven at the falling edge
// Notes: timing is counted in falling edges from a command change or an output edge, not from reset
`timescale 1ns/1ps
module test_ovst_stage;
  import ovst_pkg::*;
  localparam int TC = 8;
  localparam logic [MEAS_W-1:0] HI = 16'h1D4C;
  localparam logic [MEAS_W-1:0] LO = 16'h0FA0;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [MEAS_W-1:0] lvl_cmd = LO;
  logic [2:0] phase_mask = 3'h1;
  logic blk_cmd = 1'b0;
  logic block_in;
  logic [MEAS_W-1:0] measured_level_a, measured_level_b, measured_level_c;
  logic [MEAS_W-1:0] threshold;
  logic [1:0] pickup_phases;
  logic inverse_time_mode, delayed_release_en, cnt_reset_after_release, cont_during_release;
  logic [CNT_W-1:0] fixed_delay, release_delay;
  logic [SET_W-1:0] time_dial, inverse_time_mode_exponent;
  logic [2:0] stage_operating_mode;
  logic [VT_W-1:0] vt_primary_volts;
  logic start, trip, blocked;
  logic [CNT_W-1:0] expected_time;
  logic signed [CNT_W:0] remaining_time;
  logic [RAT_W-1:0] ratio_a, ratio_b, ratio_c, ratio_gov;
  logic [PRI_W-1:0] threshold_primary;
  logic [2:0] stage_mode_status;
  int bad_count = 0;
  int tests_run = 0;
  int c, c0;

  always #12.5 ref_clk = ~ref_clk;

  ovst_front front (.lvl_cmd(lvl_cmd), .phase_mask(phase_mask), .blk_cmd(blk_cmd), .block_in(block_in),
    .measured_level_a(measured_level_a), .measured_level_b(measured_level_b),
    .measured_level_c(measured_level_c));

  ovst_stage #(.TICK_CYCLES(TC)) dut (.ref_clk(ref_clk), .resetn(resetn), .block_in(block_in),
    .measured_level_a(measured_level_a), .measured_level_b(measured_level_b),
    .measured_level_c(measured_level_c), .threshold(threshold), .pickup_phases(pickup_phases),
    .inverse_time_mode(inverse_time_mode), .fixed_delay(fixed_delay), .time_dial(time_dial),
    .inverse_time_mode_exponent(inverse_time_mode_exponent), .release_delay(release_delay), .delayed_release_en(delayed_release_en),
    .cnt_reset_after_release(cnt_reset_after_release), .cont_during_release(cont_during_release),
    .stage_operating_mode(stage_operating_mode), .vt_primary_volts(vt_primary_volts), .start(start),
    .trip(trip), .blocked(blocked), .expected_time(expected_time), .remaining_time(remaining_time),
    .ratio_a(ratio_a), .ratio_b(ratio_b), .ratio_c(ratio_c), .ratio_gov(ratio_gov),
    .threshold_primary(threshold_primary), .stage_mode_status(stage_mode_status));

  task automatic chk(input bit ok, input string m);
    tests_run++;
    if (!ok) begin
      bad_count++;
      $display("MISMATCH t=%0t %s", $time, m);
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Bounded wait on one of start, trip, blocked; count of falling edges
  task automatic wsig(input int s, input logic v, output int n);
    n = 0;
    while (((s == 0) ? start : (s == 1) ? trip : blocked) !== v && n < 400) begin
      wt(1);
      n++;
    end
    if (n >= 400) chk(1'b0, "output wait ran out");
  endtask

  // Fresh reset with default settings, so no count leaks between scenarios
  task automatic rs;
    resetn = 1'b0;
    lvl_cmd = LO;
    phase_mask = 3'h1;
    blk_cmd = 1'b0;
    threshold = 16'h1388;
    pickup_phases = 2'h1;
    inverse_time_mode = 1'b0;
    fixed_delay = 19'h00003;
    time_dial = DEF_DIAL;
    inverse_time_mode_exponent = DEF_EXP;
    release_delay = 19'h00002;
    delayed_release_en = 1'b1;
    cnt_reset_after_release = 1'b1;
    cont_during_release = 1'b0;
    stage_operating_mode = 3'h0;
    vt_primary_volts = 20'h04E20;
    wt(20);
    resetn = 1'b1;
    wt(2);
  endtask

  task automatic s_instant;
    rs();
    fixed_delay = 19'h00000;
    lvl_cmd = HI;
    wsig(0, 1'b1, c);
    chk(trip === 1'b1 && blocked === 1'b0, "instant trip not with start");
  endtask

  task automatic s_fixed;
    rs();
    lvl_cmd = HI;
    wsig(0, 1'b1, c);
    chk(expected_time === 19'h00003, "expected time of fixed delay");
    // Remaining time is registered from the counter, one clock behind start
    wt(1);
    chk(remaining_time > 0 && remaining_time <= 3, "remaining time out of range");
    wsig(1, 1'b1, c);
    chk(c == 3 * TC - 1, "fixed delay trip timing");
  endtask

  task automatic s_release;
    rs();
    fixed_delay = 19'h00014;
    lvl_cmd = HI;
    wsig(0, 1'b1, c);
    lvl_cmd = 16'h1324;
    wt(3 * TC);
    chk(start === 1'b1, "start lost above reset ratio");
    lvl_cmd = LO;
    wsig(0, 1'b0, c);
    chk(c >= TC && c <= 3 * TC + 1 && trip === 1'b0, "release hold length");
    delayed_release_en = 1'b0;
    lvl_cmd = HI;
    wsig(0, 1'b1, c);
    lvl_cmd = LO;
    wsig(0, 1'b0, c);
    chk(c <= TC + 1, "start held without delayed release");
  endtask

  task automatic s_block;
    rs();
    fixed_delay = 19'h00014;
    blk_cmd = 1'b1;
    wt(TC);
    lvl_cmd = HI;
    wsig(2, 1'b1, c);
    chk(start === 1'b0, "start raised while blocked");
    wt(4 * TC);
    chk(trip === 1'b0 && start === 1'b0, "timing ran while blocked");
    blk_cmd = 1'b0;
    wsig(0, 1'b1, c);
    chk(c <= TC + 3, "start late after block removed");
    delayed_release_en = 1'b0;
    blk_cmd = 1'b1;
    wsig(0, 1'b0, c);
    chk(c <= TC + 3 && blocked === 1'b1 && trip === 1'b0, "block did not end start");
  endtask

  task automatic s_phases;
    for (int n = 1; n <= 3; n++) begin
      rs();
      pickup_phases = 2'(n);
      phase_mask = 3'((1 << (n - 1)) - 1);
      lvl_cmd = HI;
      wt(3 * TC);
      chk(start === 1'b0, "start with too few phases");
      phase_mask = 3'((1 << n) - 1);
      wsig(0, 1'b1, c);
      chk(c <= TC + 2, "start late with enough phases");
    end
  endtask

  task automatic s_inverse_time_mode;
    rs();
    inverse_time_mode = 1'b1;
    lvl_cmd = 16'h2710;
    wsig(0, 1'b1, c);
    wt(2);
    chk(expected_time >= 9 && expected_time <= 11, "inverse time at ratio two");
    inverse_time_mode_exponent = 13'h00C8;
    wt(2);
    chk(expected_time >= 3 && expected_time <= 4, "inverse time with exponent two");
  endtask

  task automatic s_status;
    rs();
    lvl_cmd = HI;
    wt(2);
    chk(ratio_a === 17'h00096 && ratio_b === 17'h00050, "phase ratios");
    chk(ratio_c === 17'h00050 && ratio_gov === 17'h00096, "governing ratio");
    chk(threshold_primary === 32'h000186A0, "threshold in primary volts");
    for (int m = 0; m <= 4; m++) begin
      stage_operating_mode = 3'(m);
      wt(2);
      chk(stage_mode_status === 3'(m), "operating mode status");
    end
  endtask

  // Dip inside the release time, three counter options
  // Continue option dips two ticks so the counter runs inside release
  task automatic s_counter;
    for (int k = 0; k < 3; k++) begin
      rs();
      fixed_delay = 19'h00006;
      release_delay = 19'h00004;
      cont_during_release = (k == 1);
      cnt_reset_after_release = (k != 2);
      lvl_cmd = HI;
      wsig(0, 1'b1, c);
      wt(3 * TC);
      lvl_cmd = LO;
      wt((k == 1) ? 2 * TC : TC);
      lvl_cmd = HI;
      wsig(1, 1'b1, c);
      if (k == 0) begin
        c0 = c;
        chk(c >= TC && c <= 4 * TC, "counter not held in release");
      end
      if (k == 1) chk(c < c0, "counter did not continue in release");
      if (k == 2) chk(c >= 5 * TC, "counter not cleared at drop");
    end
  endtask

  task automatic end_sim;
    $display("bad_count=%0d tests_run=%0d", bad_count, tests_run);
    if (bad_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Scenarios need under a thousand clocks; allow a wide margin
  initial begin
    repeat (30000) @(posedge ref_clk);
    bad_count++;
    end_sim();
  end

  initial begin
    rs();
    s_instant();
    s_fixed();
    s_release();
    s_block();
    s_phases();
    s_inverse_time_mode();
    s_status();
    s_counter();
    end_sim();
  end
endmodule
